// File: shared/pse_defs.vh
`ifndef PSE_DEFS_VH
`define PSE_DEFS_VH
// ----------------------------------------
// Register indices
// ----------------------------------------
`define PSE_IDX_STATUS 8'hC0
`define PSE_IDX_NMI_STAT 8'hC1
`define PSE_IDX_CTRL 8'hC2
`define PSE_IDX_CMD 8'hC3
`define PSE_IDX_NMI_MASK 8'hC4
`define PSE_IDX_RANGE 8'hC5
`define PSE_IDX_DOZE_TO 8'hCC
`define PSE_IDX_SLEEP_TO 8'hCD
`define PSE_IDX_SUSP_TO 8'hCE
`define PSE_IDX_RESUME 8'hDD
`define PSE_IDX_ACT_MASK 8'hDF
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PSE_RST_ZERO 8'h00
`define PSE_RST_CTRL 8'h01
`define PSE_RST_ACT_MASK 8'h3F
`define PSE_RST_NMI_MASK 8'hFF
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PSE_CTRL_RING_HI 3
`define PSE_CTRL_IDLE_NMI 4
`define PSE_CTRL_ADAPT 5
`define PSE_CMD_SUSP 0
`define PSE_CMD_OFF 1
`define PSE_CMD_DISP_OE 2
`define PSE_NMI_SWITCH 0
`define PSE_NMI_LOWBAT 1
`define PSE_NMI_CAUTION 2
`define PSE_NMI_IDLE 3
// ----------------------------------------
// Monitored address decodes
// ----------------------------------------
`define PSE_IO_KBD 16'h0060
`define PSE_IO_COM_A 13'h005D
`define PSE_IO_COM_B 13'h005F
`define PSE_IO_COM_C 13'h007D
`define PSE_IO_COM_D 13'h007F
`define PSE_IO_DISK_A 15'h01FB
`define PSE_IO_DISK_B 13'h003E
`define PSE_IO_CARD 15'h01F0
`define PSE_IO_WIN_HI 6'h00
`define PSE_VID_HI 3'h5
// ----------------------------------------
// Timing
// ----------------------------------------
`define PSE_CLK_NS 100
`define PSE_MS_NS 1000000
`define PSE_SW_MS 7'd60
`define PSE_SEC_LAST 10'd999
`define PSE_MIN_LAST 6'd59
`define PSE_ADAPT_MS 3'd4
`define PSE_RD0 8'd0
`define PSE_RD1 8'd10
`define PSE_RD2 8'd20
`define PSE_RD3 8'd50
`define PSE_RD4 8'd100
`define PSE_RD5 8'd150
`define PSE_RD6 8'd200
`define PSE_RD7 8'd250
`endif

// File: hdl/pse_idle_timer.v
`include "pse_defs.vh"

module pse_idle_timer #(
   parameter W = 8
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Control
   input wire run,
   input wire restart,
   input wire tick,
   input wire [W-1:0] limit,
   // Result
   output reg expire
);

   reg [W-1:0] cnt_reg;
   reg done_reg;

   // ----------------------------------------
   // Idle count, zero limit disables
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n || !run || restart) begin
         cnt_reg <= {W{1'b0}};
         done_reg <= 1'b0;
         expire <= 1'b0;
      end else begin
         expire <= 1'b0;
         if (tick && !done_reg && (limit != {W{1'b0}})) begin
            if (cnt_reg + {{(W-1){1'b0}}, 1'b1} == limit) begin
               expire <= 1'b1;
               done_reg <= 1'b1;
            end
            cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // pse_idle_timer

// File: hdl/pse_power_state_unit.v
`include "pse_defs.vh"

module pse_power_state_unit #(
   parameter integer MS_CYCLES = `PSE_MS_NS / `PSE_CLK_NS
) (
   // Clock and hard reset
   input wire clk,
   input wire rst_n,
   // Register port
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output wire [7:0] reg_rdata,
   // Bus cycles watched
   input wire bus_io_rd,
   input wire bus_io_wr,
   input wire bus_mem_wr,
   input wire [15:0] bus_io_addr,
   input wire [19:0] bus_mem_addr,
   // Monitored pins
   input wire power_switch_input,
   input wire system_power_good,
   input wire low_battery_warning_input,
   input wire battery_caution_signal,
   input wire modem_wake_input,
   // Power and clock controls
   output wire system_logic_power_enable,
   output wire memory_power_enable,
   output wire display_power_enable,
   output wire display_power_oe,
   output wire display_bias_power_enable,
   output wire display_bias_power_oe,
   output wire osc_enable,
   output wire self_refresh,
   output wire cpu_clock_slow,
   output wire cpu_run,
   output wire nmi,
   output wire [4:0] power_state
);

   localparam [4:0] ST_ON = 5'h01;
   localparam [4:0] ST_DOZE = 5'h02;
   localparam [4:0] ST_SLEEP = 5'h04;
   localparam [4:0] ST_SUSP = 5'h08;
   localparam [4:0] ST_OFF = 5'h10;

   reg [4:0] state_reg;
   reg [4:0] state_next;
   reg [7:0] range_reg, doze_to_reg, sleep_to_reg, susp_to_reg;
   reg [7:0] act_mask_reg, ctrl_reg, resume_reg, nmi_mask_reg;
   reg [3:0] nmi_stat_reg;
   reg disp_oe_reg;
   reg [7:0] rdata_reg;
   reg [31:0] ms_cnt_reg;
   reg ms_tick_reg, sec_tick_reg, min_tick_reg;
   reg [9:0] sec_cnt_reg;
   reg [5:0] min_cnt_reg;
   reg [6:0] sw_low_reg;
   reg sw_prev_reg, ring_prev_reg, lb1_prev_reg, lb2_prev_reg;
   reg [3:0] ring_cnt_reg;
   reg [2:0] adapt_cnt_reg;
   reg adapt_slow_reg;
   reg run_reg;
   reg [7:0] rd_cnt_reg;
   reg sys_pwr_reg, mem_pwr_reg, disp_pwr_reg, osc_reg, refresh_reg;
   reg slow_reg, nmi_reg;
   reg [7:0] rd_val;
   reg [7:0] rd_limit;

   // ----------------------------------------
   // Activity decode
   // ----------------------------------------
   wire io_any = bus_io_rd | bus_io_wr;
   wire [12:0] io_oct = bus_io_addr[15:3];
   wire [14:0] io_pair = bus_io_addr[15:1];
   wire act_kbd = bus_io_rd && (bus_io_addr == `PSE_IO_KBD);
   wire act_ser = io_any && (io_oct == `PSE_IO_COM_A || io_oct == `PSE_IO_COM_B ||
                  io_oct == `PSE_IO_COM_C || io_oct == `PSE_IO_COM_D);
   wire act_card = io_any && (io_pair == `PSE_IO_CARD);
   wire act_disk = io_any && (io_pair == `PSE_IO_DISK_A || io_oct == `PSE_IO_DISK_B);
   wire act_vid = bus_mem_wr && (bus_mem_addr[19:17] == `PSE_VID_HI);
   // Four-port window inside the low 1K of I/O space
   wire act_win = io_any && (bus_io_addr[15:10] == `PSE_IO_WIN_HI) &&
                  (bus_io_addr[9:2] == range_reg);
   wire [5:0] act_vec = {act_win, act_vid, act_disk, act_card, act_ser, act_kbd};
   wire act_hit = |(act_vec & act_mask_reg[5:0]);

   // ----------------------------------------
   // Pin events
   // ----------------------------------------
   wire awake = (state_reg == ST_ON) || (state_reg == ST_DOZE) || (state_reg == ST_SLEEP);
   wire sw_event = !sw_prev_reg && power_switch_input && (sw_low_reg >= `PSE_SW_MS);
   wire ring_edge = !ring_prev_reg && modem_wake_input;
   wire [3:0] ring_need = (ctrl_reg[`PSE_CTRL_RING_HI:0] == 4'h0) ? 4'h1 :
                          ctrl_reg[`PSE_CTRL_RING_HI:0];
   wire ring_wake = ring_edge && !awake && (ring_cnt_reg + 4'h1 >= ring_need);
   wire lb1_rise = !lb1_prev_reg && low_battery_warning_input;
   wire lb2_rise = !lb2_prev_reg && battery_caution_signal && awake;

   // ----------------------------------------
   // Software commands
   // ----------------------------------------
   wire cmd_wr = reg_wr && (reg_addr == `PSE_IDX_CMD);
   wire cmd_susp = cmd_wr && reg_wdata[`PSE_CMD_SUSP];
   wire cmd_off = cmd_wr && reg_wdata[`PSE_CMD_OFF];
   wire nmi_clr_wr = reg_wr && (reg_addr == `PSE_IDX_NMI_STAT);

   // ----------------------------------------
   // Idle timers
   // ----------------------------------------
   wire [2:0] t_run = {state_reg == ST_SLEEP, state_reg == ST_DOZE, state_reg == ST_ON};
   wire [2:0] t_tick = {min_tick_reg, min_tick_reg, sec_tick_reg};
   wire [23:0] t_limit = {susp_to_reg, sleep_to_reg, doze_to_reg};
   wire [2:0] t_exp;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_timer
         pse_idle_timer #(
            .W(8)
         ) u_timer (
            .clk(clk),
            .rst_n(rst_n),
            .run(t_run[gi]),
            .restart(act_hit),
            .tick(t_tick[gi]),
            .limit(t_limit[gi*8 +: 8]),
            .expire(t_exp[gi])
         );
      end
   endgenerate

   wire idle_nmi_mode = ctrl_reg[`PSE_CTRL_IDLE_NMI];

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_ON: begin
            if (cmd_off)
               state_next = ST_OFF;
            else if (cmd_susp)
               state_next = ST_SUSP;
            else if (t_exp[0] && !idle_nmi_mode)
               state_next = ST_DOZE;
         end
         ST_DOZE: begin
            if (cmd_off)
               state_next = ST_OFF;
            else if (cmd_susp)
               state_next = ST_SUSP;
            else if (act_hit)
               state_next = ST_ON;
            else if (t_exp[1])
               state_next = ST_SLEEP;
         end
         ST_SLEEP: begin
            if (cmd_off)
               state_next = ST_OFF;
            else if (cmd_susp)
               state_next = ST_SUSP;
            else if (act_hit)
               state_next = ST_ON;
            else if (t_exp[2])
               state_next = ST_SUSP;
         end
         ST_SUSP: begin
            if (sw_event || ring_wake)
               state_next = ST_ON;
         end
         ST_OFF: begin
            if (ring_wake)
               state_next = ST_ON;
         end
         default: begin
            state_next = ST_ON;
         end
      endcase
   end

   always @(posedge clk) begin
      if (!rst_n)
         state_reg <= ST_ON;
      else
         state_reg <= state_next;
   end

   // ----------------------------------------
   // Time base: ms, s, min enables
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         ms_cnt_reg <= 32'h0;
         ms_tick_reg <= 1'b0;
         sec_cnt_reg <= 10'h0;
         sec_tick_reg <= 1'b0;
         min_cnt_reg <= 6'h0;
         min_tick_reg <= 1'b0;
      end else begin
         ms_tick_reg <= 1'b0;
         sec_tick_reg <= 1'b0;
         min_tick_reg <= 1'b0;
         if (ms_cnt_reg == MS_CYCLES - 1) begin
            ms_cnt_reg <= 32'h0;
            ms_tick_reg <= 1'b1;
         end else begin
            ms_cnt_reg <= ms_cnt_reg + 32'h1;
         end
         if (ms_tick_reg) begin
            if (sec_cnt_reg == `PSE_SEC_LAST) begin
               sec_cnt_reg <= 10'h0;
               sec_tick_reg <= 1'b1;
            end else begin
               sec_cnt_reg <= sec_cnt_reg + 10'h1;
            end
         end
         if (sec_tick_reg) begin
            if (min_cnt_reg == `PSE_MIN_LAST) begin
               min_cnt_reg <= 6'h0;
               min_tick_reg <= 1'b1;
            end else begin
               min_cnt_reg <= min_cnt_reg + 6'h1;
            end
         end
      end
   end

   // ----------------------------------------
   // Pin watchers
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         sw_prev_reg <= 1'b1;
         sw_low_reg <= 7'h0;
         ring_prev_reg <= 1'b1;
         ring_cnt_reg <= 4'h0;
         lb1_prev_reg <= 1'b0;
         lb2_prev_reg <= 1'b0;
      end else begin
         sw_prev_reg <= power_switch_input;
         lb1_prev_reg <= low_battery_warning_input;
         lb2_prev_reg <= battery_caution_signal;
         ring_prev_reg <= modem_wake_input;
         // Debounce by counting free-running ms ticks seen while low, saturating at PSE_SW_MS
         if (power_switch_input)
            sw_low_reg <= 7'h0;
         else if (ms_tick_reg && sw_low_reg < `PSE_SW_MS)
            sw_low_reg <= sw_low_reg + 7'h1;
         if (awake || ring_wake)
            ring_cnt_reg <= 4'h0;
         else if (ring_edge)
            ring_cnt_reg <= ring_cnt_reg + 4'h1;
      end
   end

   // ----------------------------------------
   // Adaptive clock
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         adapt_cnt_reg <= 3'h0;
         adapt_slow_reg <= 1'b0;
      end else if (act_hit || !ctrl_reg[`PSE_CTRL_ADAPT]) begin
         // Speeds up in the same cycle as the activity is seen
         adapt_cnt_reg <= 3'h0;
         adapt_slow_reg <= 1'b0;
      end else if (ms_tick_reg && !adapt_slow_reg) begin
         if (adapt_cnt_reg + 3'h1 == `PSE_ADAPT_MS)
            adapt_slow_reg <= 1'b1;
         adapt_cnt_reg <= adapt_cnt_reg + 3'h1;
      end
   end

   // ----------------------------------------
   // Resume gate
   // ----------------------------------------
   always @* begin
      case (resume_reg[2:0])
         3'h0: rd_limit = `PSE_RD0;
         3'h1: rd_limit = `PSE_RD1;
         3'h2: rd_limit = `PSE_RD2;
         3'h3: rd_limit = `PSE_RD3;
         3'h4: rd_limit = `PSE_RD4;
         3'h5: rd_limit = `PSE_RD5;
         3'h6: rd_limit = `PSE_RD6;
         default: rd_limit = `PSE_RD7;
      endcase
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         run_reg <= 1'b0;
         rd_cnt_reg <= 8'h0;
      end else if (state_next == ST_SUSP || state_next == ST_OFF || !system_power_good) begin
         // Power loss or shutdown rearms the whole resume sequence
         run_reg <= 1'b0;
         rd_cnt_reg <= 8'h0;
      end else if (!run_reg) begin
         if (rd_cnt_reg >= rd_limit)
            run_reg <= 1'b1;
         else if (ms_tick_reg)
            rd_cnt_reg <= rd_cnt_reg + 8'h1;
      end
   end

   // ----------------------------------------
   // Registers and NMI status
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         range_reg <= `PSE_RST_ZERO;
         doze_to_reg <= `PSE_RST_ZERO;
         sleep_to_reg <= `PSE_RST_ZERO;
         susp_to_reg <= `PSE_RST_ZERO;
         act_mask_reg <= `PSE_RST_ACT_MASK;
         ctrl_reg <= `PSE_RST_CTRL;
         resume_reg <= `PSE_RST_ZERO;
         nmi_mask_reg <= `PSE_RST_NMI_MASK;
         disp_oe_reg <= 1'b0;
         nmi_stat_reg <= 4'h0;
      end else begin
         if (reg_wr) begin
            case (reg_addr)
               `PSE_IDX_RANGE: range_reg <= reg_wdata;
               `PSE_IDX_DOZE_TO: doze_to_reg <= reg_wdata;
               `PSE_IDX_SLEEP_TO: sleep_to_reg <= reg_wdata;
               `PSE_IDX_SUSP_TO: susp_to_reg <= reg_wdata;
               `PSE_IDX_ACT_MASK: act_mask_reg <= reg_wdata;
               `PSE_IDX_CTRL: ctrl_reg <= reg_wdata;
               `PSE_IDX_RESUME: resume_reg <= reg_wdata;
               `PSE_IDX_NMI_MASK: nmi_mask_reg <= reg_wdata;
               `PSE_IDX_CMD: disp_oe_reg <= reg_wdata[`PSE_CMD_DISP_OE];
               default: ;
            endcase
         end
         // Write one to clear; a new event in the same cycle wins
         nmi_stat_reg <= (nmi_stat_reg & ~(nmi_clr_wr ? reg_wdata[3:0] : 4'h0)) |
                         {t_exp[0] && idle_nmi_mode && state_reg == ST_ON,
                          lb2_rise, lb1_rise,
                          sw_event && awake};
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always @* begin
      case (reg_addr)
         `PSE_IDX_STATUS: rd_val = {run_reg, battery_caution_signal, low_battery_warning_input, state_reg};
         `PSE_IDX_NMI_STAT: rd_val = {4'h0, nmi_stat_reg};
         `PSE_IDX_CTRL: rd_val = ctrl_reg;
         `PSE_IDX_CMD: rd_val = {5'h0, disp_oe_reg, 2'h0};
         `PSE_IDX_NMI_MASK: rd_val = nmi_mask_reg;
         `PSE_IDX_RANGE: rd_val = range_reg;
         `PSE_IDX_DOZE_TO: rd_val = doze_to_reg;
         `PSE_IDX_SLEEP_TO: rd_val = sleep_to_reg;
         `PSE_IDX_SUSP_TO: rd_val = susp_to_reg;
         `PSE_IDX_RESUME: rd_val = resume_reg;
         `PSE_IDX_ACT_MASK: rd_val = act_mask_reg;
         default: rd_val = 8'h00;
      endcase
   end

   always @(posedge clk) begin
      if (!rst_n)
         rdata_reg <= 8'h00;
      else
         rdata_reg <= reg_rd ? rd_val : 8'h00;
   end

   // ----------------------------------------
   // Registered outputs, aligned with state
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         sys_pwr_reg <= 1'b1;
         mem_pwr_reg <= 1'b1;
         disp_pwr_reg <= 1'b1;
         osc_reg <= 1'b1;
         refresh_reg <= 1'b0;
         slow_reg <= 1'b0;
         nmi_reg <= 1'b0;
      end else begin
         sys_pwr_reg <= (state_next == ST_ON) || (state_next == ST_DOZE) ||
                        (state_next == ST_SLEEP);
         mem_pwr_reg <= (state_next != ST_OFF);
         disp_pwr_reg <= (state_next == ST_ON) || (state_next == ST_DOZE);
         osc_reg <= (state_next == ST_ON) || (state_next == ST_DOZE) ||
                    (state_next == ST_SLEEP);
         refresh_reg <= (state_next == ST_SUSP);
         // Adaptive slowdown is skipped on the edge that activity arrives
         slow_reg <= (state_next == ST_DOZE) ||
                     (adapt_slow_reg && !act_hit);
         nmi_reg <= |(nmi_stat_reg & ~nmi_mask_reg[3:0]);
      end
   end

   assign system_logic_power_enable = sys_pwr_reg;
   assign memory_power_enable = mem_pwr_reg;
   assign display_power_enable = disp_pwr_reg;
   assign display_bias_power_enable = disp_pwr_reg;
   // Released after reset so external pulls hold the supplies off
   assign display_power_oe = disp_oe_reg;
   assign display_bias_power_oe = disp_oe_reg;
   assign osc_enable = osc_reg;
   assign self_refresh = refresh_reg;
   assign cpu_clock_slow = slow_reg;
   assign cpu_run = run_reg;
   assign nmi = nmi_reg;
   assign power_state = state_reg;
   assign reg_rdata = rdata_reg;

endmodule // pse_power_state_unit

// File: bench/pse_far_end.sv
module pse_far_end #(
   parameter int MS = 10
) (
   // Clock
   input wire logic clk,
   // Bus cycles
   output logic bus_io_rd,
   output logic bus_io_wr,
   output logic bus_mem_wr,
   output logic [15:0] bus_io_addr,
   output logic [19:0] bus_mem_addr,
   // Pins
   output logic power_switch_input,
   output logic system_power_good,
   output logic low_battery_warning_input,
   output logic battery_caution_signal,
   output logic modem_wake_input
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // Idle levels
   // ----------------------------------------
   initial begin
      {bus_io_rd, bus_io_wr, bus_mem_wr} = 3'h0;
      bus_io_addr = 16'h0000;
      bus_mem_addr = 20'h00000;
      power_switch_input = 1'b1;
      system_power_good = 1'b1;
      low_battery_warning_input = 1'b0;
      battery_caution_signal = 1'b0;
      modem_wake_input = 1'b1;
   end
   // Released address shows its inverse, never a stale match
   task automatic io(input logic wr, input logic [15:0] a);
      @(posedge clk);
      bus_io_rd <= !wr;
      bus_io_wr <= wr;
      bus_io_addr <= a;
      @(posedge clk);
      bus_io_rd <= 1'b0;
      bus_io_wr <= 1'b0;
      bus_io_addr <= ~a;
   endtask
   task automatic vid(input logic [19:0] a);
      @(posedge clk);
      bus_mem_wr <= 1'b1;
      bus_mem_addr <= a;
      @(posedge clk);
      bus_mem_wr <= 1'b0;
      bus_mem_addr <= ~a;
   endtask
   task automatic press(input int ms);
      @(posedge clk);
      power_switch_input <= 1'b0;
      repeat (ms * MS) @(posedge clk);
      power_switch_input <= 1'b1;
   endtask
   task automatic ring();
      @(posedge clk);
      modem_wake_input <= 1'b0;
      repeat (5) @(posedge clk);
      modem_wake_input <= 1'b1;
      repeat (5) @(posedge clk);
   endtask
   task automatic lowbat();
      @(posedge clk);
      low_battery_warning_input <= 1'b1;
      repeat (5) @(posedge clk);
      low_battery_warning_input <= 1'b0;
   endtask
endmodule // pse_far_end

// File: bench/pse_power_state_unit_assertions.sv
module pse_power_state_unit_assertions (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Watched bus
   input wire bus_io_rd,
   input wire [15:0] bus_io_addr,
   // Controls
   input wire system_logic_power_enable,
   input wire memory_power_enable,
   input wire display_power_enable,
   input wire osc_enable,
   input wire self_refresh,
   input wire cpu_clock_slow,
   input wire cpu_run,
   input wire nmi,
   input wire [4:0] power_state
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   one_hot_state_a: assert property ($onehot(power_state))
      else $error("power state not one-hot");
   run_full_a: assert property (power_state == 5'h01 |-> osc_enable && display_power_enable
      && system_logic_power_enable && memory_power_enable) else $error("run state not fully powered");
   slowed_clock_a: assert property (power_state == 5'h02 |-> ##[0:1] cpu_clock_slow)
      else $error("slowed state without slow clock");
   osc_stopped_a: assert property (power_state == 5'h08 |-> !osc_enable && self_refresh
      && memory_power_enable && !system_logic_power_enable) else $error("osc-stopped outputs wrong");
   fully_off_a: assert property (power_state == 5'h10 |-> !osc_enable && !self_refresh
      && !memory_power_enable) else $error("off state outputs wrong");
   activity_wake_a: assert property ((power_state == 5'h02 || power_state == 5'h04)
      && bus_io_rd && bus_io_addr == 16'h0060 |=> power_state == 5'h01) else $error("no wake on keyboard");
   run_adjacent_a: assert property (power_state == 5'h01 |=> power_state != 5'h04)
      else $error("run skipped to display-off");
   reset_default_a: assert property ($rose(rst_n) |-> power_state == 5'h01 && !nmi && !cpu_run)
      else $error("reset state wrong");
endmodule // pse_power_state_unit_assertions

bind pse_power_state_unit pse_power_state_unit_assertions pse_power_state_unit_assertions_i (.clk, .rst_n,
   .bus_io_rd, .bus_io_addr, .system_logic_power_enable, .memory_power_enable, .display_power_enable,
   .osc_enable, .self_refresh, .cpu_clock_slow, .cpu_run, .nmi, .power_state);

// File: bench/pse_power_state_unit_bench.sv
module pse_power_state_unit_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   wire [7:0] reg_rdata;
   wire bus_io_rd, bus_io_wr, bus_mem_wr, power_switch_input, system_power_good;
   wire low_battery_warning_input, battery_caution_signal, modem_wake_input;
   wire [15:0] bus_io_addr;
   wire [19:0] bus_mem_addr;
   wire system_logic_power_enable, memory_power_enable, display_power_enable, display_power_oe;
   wire display_bias_power_enable, display_bias_power_oe, osc_enable, self_refresh, cpu_clock_slow, cpu_run, nmi;
   wire [4:0] power_state;
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;
   // Short millisecond keeps second-scale timers within the run
   pse_power_state_unit #(.MS_CYCLES(10)) pse_power_state_unit_i (.clk, .rst_n, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .bus_io_rd, .bus_io_wr, .bus_mem_wr, .bus_io_addr, .bus_mem_addr,
      .power_switch_input, .system_power_good, .low_battery_warning_input, .battery_caution_signal,
      .modem_wake_input, .system_logic_power_enable, .memory_power_enable, .display_power_enable,
      .display_power_oe, .display_bias_power_enable, .display_bias_power_oe, .osc_enable, .self_refresh,
      .cpu_clock_slow, .cpu_run, .nmi, .power_state);
   pse_far_end #(.MS(10)) pse_far_end_i (.clk, .bus_io_rd, .bus_io_wr, .bus_mem_wr, .bus_io_addr,
      .bus_mem_addr, .power_switch_input, .system_power_good, .low_battery_warning_input,
      .battery_caution_signal, .modem_wake_input);
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         wrap_up();
      end
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk("register", e, reg_rdata);
   endtask
   task automatic wait_st(input logic [4:0] s, input int lim);
      int n;
      n = 0;
      while (power_state !== s && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk("power_state", {3'h0, s}, {3'h0, power_state});
   endtask
   task automatic act(input int k, input logic [19:0] a, input logic w);
      int n;
      n = 0;
      while (cpu_clock_slow !== 1'b1 && n < 80) begin
         @(negedge clk);
         n++;
      end
      if (k == 2) pse_far_end_i.vid(a);
      else pse_far_end_i.io(k[0], a[15:0]);
      repeat (3) @(negedge clk);
      chk("cpu_clock_slow", {7'h00, !w}, {7'h00, cpu_clock_slow});
   endtask
   task automatic wrap_up();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      rd(8'hC2, 8'h01);
      rd(8'hC4, 8'hFF);
      rd(8'hDF, 8'h3F);
      rd(8'hCC, 8'h00);
      rd(8'hD0, 8'h00);
      wr(8'hC5, 8'hA5);
      rd(8'hC5, 8'hA5);
      rd(8'hC0, 8'h81);
      wr(8'hC3, 8'h04);
      @(negedge clk);
      chk("display_oe", 8'h01, {7'h00, display_power_oe});
      chk("bias_oe", 8'h01, {7'h00, display_bias_power_oe});
   endtask
   task automatic t_sources();
      wr(8'hC2, 8'h21);
      act(0, 20'h00060, 1'b1);
      act(1, 20'h00060, 1'b0);
      act(1, 20'h002EF, 1'b1);
      act(0, 20'h003F8, 1'b1);
      act(1, 20'h003F7, 1'b1);
      act(0, 20'h001F0, 1'b1);
      act(0, 20'h001F8, 1'b0);
      act(2, 20'hA0000, 1'b1);
      act(0, 20'h003E0, 1'b1);
      act(1, 20'h00294, 1'b1);
      wr(8'hDF, 8'h2F);
      act(2, 20'hB0000, 1'b0);
      wr(8'hDF, 8'h3F);
      wr(8'hC2, 8'h01);
   endtask
   task automatic t_timer();
      wr(8'hCC, 8'h02);
      wait_st(5'h02, 25000);
      chk("display_on", 8'h01, {7'h00, display_power_enable});
      pse_far_end_i.io(1'b0, 16'h0060);
      wait_st(5'h01, 2);
      wr(8'hCC, 8'h00);
   endtask
   task automatic t_nmi();
      wr(8'hC4, 8'hFC);
      pse_far_end_i.lowbat();
      chk("nmi", 8'h01, {7'h00, nmi});
      rd(8'hC1, 8'h02);
      wr(8'hC1, 8'h02);
      repeat (3) @(negedge clk);
      chk("nmi", 8'h00, {7'h00, nmi});
      pse_far_end_i.press(65);
      repeat (4) @(negedge clk);
      chk("nmi", 8'h01, {7'h00, nmi});
      wr(8'hC1, 8'h01);
      wr(8'hC4, 8'hFF);
   endtask
   task automatic t_suspend();
      wr(8'hC3, 8'h01);
      wait_st(5'h08, 5);
      pse_far_end_i.io(1'b0, 16'h0060);
      wait_st(5'h08, 3);
      pse_far_end_i.press(65);
      wait_st(5'h01, 20);
   endtask
   task automatic t_off();
      wr(8'hC2, 8'h02);
      wr(8'hC3, 8'h02);
      wait_st(5'h10, 5);
      pse_far_end_i.ring();
      wait_st(5'h10, 1);
      pse_far_end_i.ring();
      wait_st(5'h01, 20);
      repeat (10) @(negedge clk);
      chk("cpu_run", 8'h01, {7'h00, cpu_run});
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_sources();
      t_timer();
      t_nmi();
      t_suspend();
      t_off();
      wrap_up();
   end
endmodule // pse_power_state_unit_bench
